// ---- rtl/iocn_port.sv ----
// Top of the I/O port with change notification.
// Assumes control words come from same-clock logic; pins are asynchronous.
//
// What this block does
// - Open-drain select makes pin drive low only.
// - Analog pin driven as output converts driven level.
// - Analog/digital select resets to zero, analog.
// - Analog pins read as zero.
// - Digital inputs are not routed to converter.
// - Enabled pin change raises interrupt request.
// - Change detection works while clocks stop.
// - At most sixteen change-notify inputs.
// - Per-pin enable gates change interrupt.
// - Per-pin pull-up enable turns weak pull-up on.
`timescale 1ns/10ps
`default_nettype none
module iocn_port #(
    parameter int unsigned WIDTH = iocn_pkg::PORT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             cfg_we,
    input  wire logic [WIDTH-1:0] direction_select_wr,
    input  wire logic [WIDTH-1:0] output_latch_wr,
    input  wire logic [WIDTH-1:0] open_drain_select_wr,
    input  wire logic [WIDTH-1:0] analog_digital_select_wr,
    input  wire logic [WIDTH-1:0] change_irq_enable_wr,
    input  wire logic [WIDTH-1:0] weak_pullup_enable_wr,
    input  wire logic             change_flag_clr,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_out,
    output var  logic [WIDTH-1:0] pin_oe,
    output var  logic [WIDTH-1:0] pullup_on,
    output var  logic [WIDTH-1:0] adc_level,
    output var  logic [WIDTH-1:0] adc_route,
    output var  logic [WIDTH-1:0] port_value,
    output var  logic [WIDTH-1:0] direction_select,
    output var  logic [WIDTH-1:0] output_latch,
    output var  logic [WIDTH-1:0] analog_digital_select,
    output var  logic             change_flag,
    output var  logic             wake_req
);
    // ==========================================================
    // Configuration registers
    // ==========================================================
    // All six words load on one strobe, so a pin never shows a mix of
    // old and new settings; software rewrites every word each time.
    logic cfg_load;

    assign cfg_load = clk_en && cfg_we;

    // Direction: a set bit makes the pin an input. Pins start as inputs
    // so nothing is driven onto the board before software decides.
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;

    always_comb begin
        dir_d = dir_q;
        if (cfg_load) begin
            dir_d = direction_select_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= WIDTH'(iocn_pkg::DIRECTION_RST);
        end else begin
            dir_q <= dir_d;
        end
    end

    // Output latch: the level driven on pins set as outputs.
    logic [WIDTH-1:0] lat_q;
    logic [WIDTH-1:0] lat_d;

    always_comb begin
        lat_d = lat_q;
        if (cfg_load) begin
            lat_d = output_latch_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lat_q <= WIDTH'(iocn_pkg::LATCH_RST);
        end else begin
            lat_q <= lat_d;
        end
    end

    // Open-drain select: a set bit lets the pin pull low only; the high
    // level then comes from a pull-up outside the block.
    logic [WIDTH-1:0] od_q;
    logic [WIDTH-1:0] od_d;

    always_comb begin
        od_d = od_q;
        if (cfg_load) begin
            od_d = open_drain_select_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            od_q <= WIDTH'(iocn_pkg::OPEN_DRAIN_RST);
        end else begin
            od_q <= od_d;
        end
    end

    // Analog/digital select: a clear bit gives the pin to the converter.
    // Reset leaves every shared pin analog, which draws no input current.
    logic [WIDTH-1:0] ads_q;
    logic [WIDTH-1:0] ads_d;

    always_comb begin
        ads_d = ads_q;
        if (cfg_load) begin
            ads_d = analog_digital_select_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ads_q <= WIDTH'(iocn_pkg::ANALOG_SEL_RST);
        end else begin
            ads_q <= ads_d;
        end
    end

    // Change enables: only these pins can raise the change flag.
    logic [WIDTH-1:0] cen_q;
    logic [WIDTH-1:0] cen_d;

    always_comb begin
        cen_d = cen_q;
        if (cfg_load) begin
            cen_d = change_irq_enable_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cen_q <= WIDTH'(iocn_pkg::CHG_EN_RST);
        end else begin
            cen_q <= cen_d;
        end
    end

    // Weak pull-ups: useful with buttons on inputs; software should
    // leave them off on pins that it drives.
    logic [WIDTH-1:0] pu_q;
    logic [WIDTH-1:0] pu_d;

    always_comb begin
        pu_d = pu_q;
        if (cfg_load) begin
            pu_d = weak_pullup_enable_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pu_q <= WIDTH'(iocn_pkg::PULLUP_RST);
        end else begin
            pu_q <= pu_d;
        end
    end

    assign direction_select      = dir_q;
    assign output_latch          = lat_q;
    assign analog_digital_select = ads_q;

    // ==========================================================
    // Pin synchronisation and per-pin cells
    // ==========================================================
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] port_rd;

    iocn_sync2 #(.WIDTH(WIDTH)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        iocn_pin_cell u_cell (
            .pin_sync              (pin_sync[i]),
            .pin_raw               (pin_in[i]),
            .direction_select      (dir_q[i]),
            .output_latch          (lat_q[i]),
            .open_drain_select     (od_q[i]),
            .analog_digital_select (ads_q[i]),
            .weak_pullup_enable    (pu_q[i]),
            .pin_out               (pin_out[i]),
            .pin_oe                (pin_oe[i]),
            .pullup_on             (pullup_on[i]),
            .port_read             (port_rd[i]),
            .adc_level             (adc_level[i]),
            .adc_route             (adc_route[i])
        );
    end

    // ==========================================================
    // Read-back and change notification
    // ==========================================================
    // Only the low sixteen pins can carry a change-notice input.
    localparam int unsigned NCN =
        (WIDTH < iocn_pkg::CHANGE_PIN_MAX) ? WIDTH : iocn_pkg::CHANGE_PIN_MAX;

    // Read-back lags the synchronised pins by one cycle; after a
    // direction or latch change software waits out the synchroniser too.
    logic [WIDTH-1:0] pv_q;
    logic [WIDTH-1:0] pv_d;

    always_comb begin
        pv_d = pv_q;
        if (clk_en) begin
            pv_d = port_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pv_q <= '0;
        end else begin
            pv_q <= pv_d;
        end
    end

    assign port_value = pv_q;

    // ==========================================================
    // Change notification
    // ==========================================================
    // The last sample is the reference for change detection. It resets
    // low but follows pin_sync on every clk_en cycle, so enabling a pin that is already high does not flag.
    logic [WIDTH-1:0] last_q;
    logic [WIDTH-1:0] last_d;

    always_comb begin
        last_d = last_q;
        if (clk_en) begin
            last_d = pin_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_q <= '0;
        end else begin
            last_q <= last_d;
        end
    end

    logic [NCN-1:0] diff;
    logic           state_change;

    always_comb begin
        diff         = (pin_sync[NCN-1:0] ^ last_q[NCN-1:0])
                     & cen_q[NCN-1:0];
        state_change = |diff;
    end

    // A change seen in the clear cycle keeps the flag set, so an event
    // that lands between reading the flag and clearing it is not lost.
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clk_en) begin
            if (state_change) begin
                flag_d = 1'b1;
            end else if (change_flag_clr) begin
                flag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign change_flag = flag_q;

    // While clocks are stopped the raw pins are compared with the last
    // sampled level, so a change can wake the processor without edges.
    // This path skips the synchroniser on purpose: a glitch may wake the
    // processor for nothing, which costs power but never loses a change.
    logic [NCN-1:0] wake_diff;

    always_comb begin
        wake_diff = (pin_in[NCN-1:0] ^ last_q[NCN-1:0])
                  & cen_q[NCN-1:0];
        wake_req  = |wake_diff;
    end
endmodule : iocn_port
`default_nettype wire

// ---- rtl/iocn_pkg.sv ----
// Package for the port and change-notice block: widths and reset values.
// Assumes nothing of its surroundings; every file names items as pkg::name.
package iocn_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned PORT_WIDTH      = 16;
    localparam int unsigned CHANGE_PIN_MAX  = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] ANALOG_SEL_RST  = 16'h0000;
    localparam logic [15:0] DIRECTION_RST   = 16'hffff;
    localparam logic [15:0] LATCH_RST       = 16'h0000;
    localparam logic [15:0] OPEN_DRAIN_RST  = 16'h0000;
    localparam logic [15:0] CHG_EN_RST      = 16'h0000;
    localparam logic [15:0] PULLUP_RST      = 16'h0000;

endpackage : iocn_pkg

// ---- rtl/iocn_sync2.sv ----
// Two-flip-flop synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/10ps
`default_nettype none
module iocn_sync2 #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        if (clk_en) begin
            meta_d = async_in;
            sync_d = meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : iocn_sync2
`default_nettype wire

// ---- rtl/iocn_pin_cell.sv ----
// One I/O pin: drive, open-drain, pull-up and converter routing.
// Assumes the pin level arrives already synchronised for the read path.
`timescale 1ns/10ps
`default_nettype none
module iocn_pin_cell (
    input  wire logic pin_sync,
    input  wire logic pin_raw,
    input  wire logic direction_select,
    input  wire logic output_latch,
    input  wire logic open_drain_select,
    input  wire logic analog_digital_select,
    input  wire logic weak_pullup_enable,
    output var  logic pin_out,
    output var  logic pin_oe,
    output var  logic pullup_on,
    output var  logic port_read,
    output var  logic adc_level,
    output var  logic adc_route
);
    logic drive_en;
    logic analog;

    always_comb begin
        analog   = ~analog_digital_select;
        drive_en = ~direction_select;
        // An open-drain pin only pulls low and lets go for a high.
        pin_out  = open_drain_select ? 1'b0 : output_latch;
        pin_oe   = drive_en & (~open_drain_select | ~output_latch);
        pullup_on = weak_pullup_enable;
        port_read = analog ? 1'b0 : pin_sync;
        adc_route = analog;
        // With the driver on, the converter sees the driven level.
        adc_level = drive_en ? output_latch : pin_raw;
    end
endmodule : iocn_pin_cell
`default_nettype wire

// ---- testbench/iocn_port_chk.sv ----
// Assertions on the top ports of the I/O port block, bound after it.
// Assumes the default sixteen-pin width and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module iocn_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        cfg_we,
    input wire logic        change_flag_clr,
    input wire logic        change_flag,
    input wire logic        wake_req,
    input wire logic [15:0] open_drain_select_wr,
    input wire logic [15:0] change_irq_enable_wr,
    input wire logic [15:0] weak_pullup_enable_wr,
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pullup_on,
    input wire logic [15:0] adc_level,
    input wire logic [15:0] adc_route,
    input wire logic [15:0] port_value,
    input wire logic [15:0] direction_select,
    input wire logic [15:0] output_latch,
    input wire logic [15:0] analog_digital_select
);
    // ==========================================================
    // Mirrors of the registers that have no output port
    // ==========================================================
    logic [15:0] od_q, en_q, pu_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {od_q, en_q, pu_q} <= '0;
        end else if (cfg_we && clk_en) begin
            od_q <= open_drain_select_wr;
            en_q <= change_irq_enable_wr;
            pu_q <= weak_pullup_enable_wr;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // An enabled pin differs from the last sample while running.
    sequence s_pend;
        wake_req && clk_en && !change_flag_clr;
    endsequence
    // An enabled pin moves while the clock enable has been held low.
    sequence s_frozen_change;
        $past(!clk_en) && !clk_en && !$past(wake_req)
            && |((pin_in ^ $past(pin_in)) & en_q);
    endsequence
    a_od_no_high: assert property
        ((pin_oe & od_q & pin_out) == 16'h0000)
        else $error("open-drain pin driven high");
    a_adc_own_level: assert property
        (((adc_level ^ output_latch) & ~direction_select) == 16'h0000)
        else $error("converter does not see driven level");
    a_reset_analog: assert property
        (@(posedge clk) disable iff (1'b0)
         !rst_n |=> analog_digital_select == 16'h0000)
        else $error("select not analog after reset");
    a_analog_reads_zero: assert property
        ((port_value & ~analog_digital_select
          & ~$past(analog_digital_select)) == 16'h0000)
        else $error("analog pin reads nonzero");
    a_digital_unrouted: assert property
        (adc_route == ~analog_digital_select)
        else $error("converter routing wrong");
    a_flag_sets: assert property
        (s_pend ##1 s_pend |-> ##[1:3] (change_flag || change_flag_clr))
        else $error("change flag not raised");
    a_wake_asleep: assert property
        (s_frozen_change |-> wake_req)
        else $error("no wake on change while frozen");
    a_enable_gates: assert property
        (en_q == 16'h0000 |-> !wake_req)
        else $error("wake without enabled pin");
    a_pullup_follow: assert property
        (pullup_on == pu_q)
        else $error("pull-up does not follow enable");
    a_flag_sticky: assert property
        (change_flag && !change_flag_clr && clk_en |=> change_flag)
        else $error("change flag dropped");
endmodule : iocn_chk
bind iocn_port iocn_chk i_chk (.*);
`default_nettype wire

// ---- testbench/iocn_pins.sv ----
// Pins, buttons and weak pull-ups outside the port block.
// Assumes the bench sets which pins a button drives and to what level.
`timescale 1ns/10ps
`default_nettype none
module iocn_pins (
    input  wire logic        clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [15:0] pullup_on,
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_en,
    output var  logic [15:0] pin_in
);
    // ==========================================================
    // Wire level
    // ==========================================================
    logic [15:0] flip_q = 16'h5555;
    always_ff @(posedge clk) flip_q <= ~flip_q;
    // An undriven pin without pull-up wanders, so it never reads stable.
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_on | flip_q));
endmodule : iocn_pins
`default_nettype wire

// ---- testbench/io_port_change_notify_tb.sv ----
// Self-checking bench for the I/O port with change notification.
// Assumes the pin model and checker files are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module io_port_change_notify_tb;
    logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic cfg_we = 1'b0, change_flag_clr = 1'b0;
    logic [15:0] direction_select_wr = 16'hffff, output_latch_wr = '0;
    logic [15:0] open_drain_select_wr = '0, analog_digital_select_wr = '0;
    logic [15:0] change_irq_enable_wr = '0, weak_pullup_enable_wr = '0;
    logic [15:0] ext_val = '0, ext_en = '0;
    wire logic [15:0] pin_in, pin_out, pin_oe, pullup_on, adc_level;
    wire logic [15:0] adc_route, port_value, direction_select;
    wire logic [15:0] output_latch, analog_digital_select;
    wire logic        change_flag, wake_req;
    int n_fail = 0, num_checks = 0, cyc = 0;
    iocn_port i_dut (.*);
    iocn_pins i_pins (.*);
    always #12.5 clk = ~clk;
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input logic [15:0] d, l, o, a, e, p);
        @(posedge clk);
        cfg_we <= 1'b1;
        direction_select_wr <= d;
        output_latch_wr <= l;
        open_drain_select_wr <= o;
        analog_digital_select_wr <= a;
        change_irq_enable_wr <= e;
        weak_pullup_enable_wr <= p;
        @(posedge clk);
        cfg_we <= 1'b0;
        @(posedge clk) #1;
    endtask : cfg
    task automatic pulse_clr;
        @(posedge clk) change_flag_clr <= 1'b1;
        @(posedge clk) change_flag_clr <= 1'b0;
        @(posedge clk) #1;
    endtask : pulse_clr
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_drive;
        cfg(16'h0000, 16'h00ff, 16'h0f0f, 16'hff00, '0, '0);
        chk(pin_out, 16'h00f0);
        chk(pin_oe, 16'hfff0);
        chk(adc_level, 16'h00ff);
        chk(adc_route, 16'h00ff);
        chk(output_latch, 16'h00ff);
        $display("drive test done");
    endtask : t_drive
    task automatic t_read;
        @(posedge clk) ext_en <= 16'hffff;
        ext_val <= 16'ha5a5;
        cfg(16'hffff, '0, '0, 16'h00ff, '0, 16'h00f0);
        settle(4);
        chk(port_value, 16'h00a5);
        chk(adc_level, 16'ha5a5);
        chk(pullup_on, 16'h00f0);
        $display("read test done");
    endtask : t_read
    task automatic t_change;
        @(posedge clk) ext_val <= 16'h0000;
        cfg(16'hffff, '0, '0, 16'hffff, 16'h0001, '0);
        settle(4);
        pulse_clr();
        @(posedge clk) ext_val <= 16'h0002;
        settle(5);
        chk(change_flag, 16'h0000);
        @(posedge clk) ext_val <= 16'h0003;
        settle(8);
        chk(change_flag, 16'h0001);
        pulse_clr();
        chk(change_flag, 16'h0000);
        @(posedge clk) clk_en <= 1'b0;
        settle(2);
        @(posedge clk) ext_val <= 16'h0002;
        settle(2);
        chk(wake_req, 16'h0001);
        chk(change_flag, 16'h0000);
        @(posedge clk) clk_en <= 1'b1;
        settle(5);
        chk(change_flag, 16'h0001);
        $display("change test done");
    endtask : t_change
    initial begin
        repeat (5) @(posedge clk);
        #1;
        chk(analog_digital_select, 16'h0000);
        chk(direction_select, 16'hffff);
        @(posedge clk) rst_n <= 1'b1;
        t_drive();
        t_read();
        t_change();
        conclude();
    end
endmodule : io_port_change_notify_tb
`default_nettype wire
